//--- dsrc_top.sv
// Function
// - pre-trigger length from zero to full sweep
// - early trigger truncates pre-trigger to recorded samples
// - delayed trigger up to one thousand seconds
// - delayed sweep is all post-trigger
// - limit sweeps per recording and pending sweeps
// - at most four hundred sweeps per second
// - zero re-arm, starts spaced 2.5 ms
// - stretch restarts post-trigger count on trigger
// - skip stretch when post does not fit
// - stretches spaced at least 2.5 ms
// - continuous data stored before sweep data
// - sweep storage starts right after trigger
// - release sweep memory after all channels stored
// - store sweeps one at a time in order
// - on overrun store markers, not sweeps
// - resume sweeps when whole sweep fits
// - throttle sweep storage when stream rate exceeded
// - full continuous FIFO suspends recording, keeps draining
// - resume only when both memories empty
// - notification entries mark suspend periods
// - end on media full or duration elapsed
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "dsrc_defs.svh"
module dsrc_top #(
  parameter int AW      = 20,
  parameter int NCH     = 8,
  parameter int CW      = 3,
  parameter int PW      = 11,
  parameter int MS_CYC  = `DSRC_CYC(`DSRC_MS_US),
  parameter int GAP_CYC = `DSRC_CYC(`DSRC_GAP_US)
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sample_tick,
  input  wire logic              trig_in,
  output logic                   cap_we,
  output logic [AW-1:0]          cap_addr,
  output logic                   rec_active,
  input  wire logic              cont_valid,
  input  wire logic [31:0]       cont_data,
  output logic                   cont_ready,
  input  wire logic              cont_fifo_full,
  input  wire logic              cont_fifo_empty,
  input  wire logic              rate_over,
  input  wire logic              media_full,
  output logic                   st_valid,
  input  wire logic              st_ready,
  output dsrc_pkg::dsrc_kind_t   st_kind,
  output logic [CW-1:0]          st_chan,
  output logic [31:0]            st_data
);
  import dsrc_pkg::*;

  localparam logic [AW:0] MEM_WORDS = {1'b1, {AW{1'b0}}};

  // sweep word address with pre-trigger ring rotation undone
  function automatic logic [AW-1:0] dsrc_addr(input logic [AW-1:0] base,
      input logic [AW:0] rot, input logic [AW:0] pre, input logic [AW:0] i);
    logic [AW:0] j;
    j = rot + i;
    if (j >= pre) j = j - pre;
    if (i >= pre) j = i;
    return base + j[AW-1:0];
  endfunction

  // lowest enabled channel at or above from, NCH if none
  function automatic logic [CW:0] dsrc_next_ch(input logic [NCH-1:0] m,
      input logic [CW:0] from);
    logic [CW:0] r;
    r = (CW+1)'(NCH);
    for (int k = NCH-1; k >= 0; k--)
      if (m[k] && (k >= int'(from))) r = (CW+1)'(k);
    return r;
  endfunction

  // descriptor ring pointer step
  function automatic logic [PW-1:0] dsrc_inc(input logic [PW-1:0] p);
    return (p == PW'(`DSRC_MAX_PEND - 1)) ? '0 : p + 1'b1;
  endfunction

  // ---------------- register file ----------------
  logic [AW:0]     len_r, next_len_r;        // sweep length
  logic [AW:0]     pre_r, next_pre_r;        // pre-trigger length
  logic [19:0]     dly_r, next_dly_r;        // trigger delay in ms
  logic [31:0]     dur_r, next_dur_r;        // duration in ms, 0 = none
  logic [NCH-1:0]  chan_r, next_chan_r;      // enabled channels
  logic            str_r, next_str_r;        // stretch enable
  logic [31:0]     next_prdata;
  logic            next_pslverr;
  logic            arm_p, stop_p;            // control pulses
  // ---------------- recording control ----------------
  dsrc_rec_t       rec, next_rec;
  logic [15:0]     ms_cnt, next_ms_cnt;
  logic [31:0]     el_ms, next_el_ms;        // elapsed ms
  logic            ms_tick, note_set, note_dir;
  logic [AW:0]     c_len, c_pre, c_post, next_c_len, next_c_pre, next_c_post;
  logic [19:0]     c_dly, next_c_dly;
  logic [31:0]     c_dur, next_c_dur;
  logic [NCH-1:0]  c_chan, next_c_chan;
  logic            c_str, next_c_str;
  // ---------------- capture ----------------
  dsrc_cap_t       cap, next_cap;
  logic [AW:0]     pre_pos, pre_cnt, next_pre_pos, next_pre_cnt;
  logic [AW-1:0]   tail, next_tail;          // base of next sweep
  logic [AW:0]     wr_off, post_cnt, post_tgt;
  logic [AW:0]     next_wr_off, next_post_cnt, next_post_tgt;
  logic [19:0]     dly_cnt, gap_cnt, str_cnt;
  logic [19:0]     next_dly_cnt, next_gap_cnt, next_str_cnt;
  logic [17:0]     sweeps, next_sweeps;      // sweeps this recording
  logic [PW-1:0]   wr_ptr, cur_ptr, next_wr_ptr, next_cur_ptr;
  logic            open, next_open, overrun, next_overrun;
  logic            next_cap_we;
  logic [AW-1:0]   next_cap_addr;
  logic            do_commit, push, fin, mark_set, used_add;
  logic [AW:0]     com_pre, com_post, fin_len, push_rot, used_pre;
  // descriptor memory
  logic [AW-1:0]   d_base [`DSRC_MAX_PEND];
  logic [AW:0]     d_len  [`DSRC_MAX_PEND];
  logic [AW:0]     d_pre  [`DSRC_MAX_PEND];
  logic [AW:0]     d_rot  [`DSRC_MAX_PEND];
  // ---------------- storage ----------------
  logic            next_st_valid;
  dsrc_kind_t      next_st_kind;
  logic [CW-1:0]   next_st_chan;
  logic [31:0]     next_st_data;
  logic [AW:0]     used, next_used, s_idx, next_s_idx, lim;
  logic [PW-1:0]   pend, rd_ptr, next_pend, next_rd_ptr;
  logic [CW:0]     s_ch, next_s_ch, nx_ch;
  logic [3:0]      thr, next_thr;            // throttle level
  logic [2:0]      phase, next_phase;
  logic            note_p, note_v, mark_p, next_note_p, next_note_v;
  logic            next_mark_p, rel, head_open, allow;
  logic [AW:0]     free;

  assign free       = MEM_WORDS - used;
  assign pready     = 1'b1;
  assign rec_active = (rec == REC_RUN);
  assign ms_tick    = (ms_cnt == 16'(MS_CYC - 1));

  // apb decode: writes in access phase, read data staged in setup
  always_comb begin
    next_len_r = len_r;
    next_pre_r = pre_r;
    next_dly_r = dly_r;
    next_dur_r = dur_r;
    next_chan_r = chan_r;
    next_str_r = str_r;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    arm_p = 1'b0;
    stop_p = 1'b0;
    if (psel && penable && pwrite) begin
      unique case (paddr)
        `DSRC_A_CTRL: begin
          arm_p = pwdata[`DSRC_C_ARM];
          stop_p = pwdata[`DSRC_C_STOP];
          next_str_r = pwdata[`DSRC_C_STR];
        end
        `DSRC_A_LEN:  next_len_r = pwdata[AW:0];
        `DSRC_A_PRE:  next_pre_r = pwdata[AW:0];
        `DSRC_A_DLY:  next_dly_r = pwdata[19:0];
        `DSRC_A_DUR:  next_dur_r = pwdata;
        `DSRC_A_CHAN: next_chan_r = pwdata[NCH-1:0];
        default: ;
      endcase
    end
    if (psel && !penable) begin
      next_prdata = '0;
      unique case (paddr)
        `DSRC_A_CTRL: next_prdata[`DSRC_C_STR] = str_r;
        `DSRC_A_LEN:  next_prdata[AW:0] = len_r;
        `DSRC_A_PRE:  next_prdata[AW:0] = pre_r;
        `DSRC_A_DLY:  next_prdata[19:0] = dly_r;
        `DSRC_A_DUR:  next_prdata = dur_r;
        `DSRC_A_CHAN: next_prdata[NCH-1:0] = chan_r;
        `DSRC_A_STAT: next_prdata[11:0] = {thr, cap, rec == REC_DONE,
                          overrun, rec == REC_SUSP, rec == REC_RUN};
        `DSRC_A_SWPS: next_prdata[17:0] = sweeps;
        `DSRC_A_PEND: next_prdata[PW-1:0] = pend;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_r <= (AW+1)'(`DSRC_R_LEN);
      pre_r <= (AW+1)'(`DSRC_R_PRE);
      dly_r <= '0;
      dur_r <= '0;
      chan_r <= NCH'(`DSRC_R_CHAN);
      str_r <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      len_r <= next_len_r;
      pre_r <= next_pre_r;
      dly_r <= next_dly_r;
      dur_r <= next_dur_r;
      chan_r <= next_chan_r;
      str_r <= next_str_r;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // recording control: arm, suspend, resume, end
  always_comb begin
    next_rec = rec;
    next_ms_cnt = ms_tick ? '0 : ms_cnt + 1'b1;
    next_el_ms = el_ms;
    next_c_len = c_len;
    next_c_pre = c_pre;
    next_c_post = c_post;
    next_c_dly = c_dly;
    next_c_dur = c_dur;
    next_c_chan = c_chan;
    next_c_str = c_str;
    note_set = 1'b0;
    note_dir = 1'b0;
    if ((rec == REC_RUN || rec == REC_SUSP) && ms_tick)
      next_el_ms = el_ms + 1'b1;
    unique case (rec)
      REC_IDLE, REC_DONE: if (arm_p) begin
        next_rec = REC_RUN;
        next_el_ms = '0;
        next_c_len = len_r;
        next_c_pre = (pre_r > len_r) ? len_r : pre_r;
        next_c_post = len_r - next_c_pre;
        next_c_dly = (dly_r > 20'(`DSRC_MAX_DELAY_MS)) ?
                     20'(`DSRC_MAX_DELAY_MS) : dly_r;
        next_c_dur = dur_r;
        next_c_chan = (chan_r == '0) ? NCH'(1) : chan_r;
        next_c_str = next_str_r;
      end
      REC_RUN: if (cont_fifo_full) begin
        next_rec = REC_SUSP;
        note_set = 1'b1;
      end
      REC_SUSP: if (cont_fifo_empty && pend == '0 && !open) begin
        next_rec = REC_RUN;
        note_set = 1'b1;
        note_dir = 1'b1;
      end
    endcase
    if ((rec == REC_RUN || rec == REC_SUSP) && (stop_p || media_full ||
        (c_dur != '0 && el_ms >= c_dur)))
      next_rec = REC_DONE;
  end

  // recording control flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec <= REC_IDLE;
      ms_cnt <= '0;
      el_ms <= '0;
      c_len <= '0;
      c_pre <= '0;
      c_post <= '0;
      c_dly <= '0;
      c_dur <= '0;
      c_chan <= '0;
      c_str <= 1'b0;
    end else begin
      rec <= next_rec;
      ms_cnt <= next_ms_cnt;
      el_ms <= next_el_ms;
      c_len <= next_c_len;
      c_pre <= next_c_pre;
      c_post <= next_c_post;
      c_dly <= next_c_dly;
      c_dur <= next_c_dur;
      c_chan <= next_c_chan;
      c_str <= next_c_str;
    end
  end

  // sweep capture: pre ring, delay, post with stretch
  always_comb begin
    next_cap = cap;
    next_pre_pos = pre_pos;
    next_pre_cnt = pre_cnt;
    next_tail = tail;
    next_wr_off = wr_off;
    next_post_cnt = post_cnt;
    next_post_tgt = post_tgt;
    next_dly_cnt = dly_cnt;
    next_gap_cnt = (gap_cnt >= 20'(GAP_CYC)) ? gap_cnt : gap_cnt + 1'b1;
    next_str_cnt = (str_cnt >= 20'(GAP_CYC)) ? str_cnt : str_cnt + 1'b1;
    next_sweeps = sweeps;
    next_wr_ptr = wr_ptr;
    next_cur_ptr = cur_ptr;
    next_open = open;
    next_overrun = overrun;
    next_cap_we = 1'b0;
    next_cap_addr = cap_addr;
    do_commit = 1'b0;
    com_pre = pre_cnt;
    com_post = c_post;
    push = 1'b0;
    fin = 1'b0;
    fin_len = wr_off;
    mark_set = 1'b0;
    used_add = 1'b0;
    used_pre = '0;
    push_rot = (pre_cnt == c_pre) ? pre_pos : '0;
    unique case (cap)
      CAP_IDLE: if (rec == REC_RUN) begin
        next_cap = CAP_PRE;
        next_pre_pos = '0;
        next_pre_cnt = '0;
      end
      CAP_PRE: begin
        if (rec != REC_RUN) next_cap = CAP_IDLE;
        else if (trig_in && gap_cnt >= 20'(GAP_CYC) &&
                 sweeps < 18'(`DSRC_MAX_SWEEPS)) begin
          if (c_dly != '0) begin
            next_cap = CAP_DLY;
            next_dly_cnt = '0;
          end else do_commit = 1'b1;
        end else if (sample_tick && c_pre != '0) begin
          if (free >= c_len) begin
            next_cap_we = 1'b1;
            next_cap_addr = tail + pre_pos[AW-1:0];
            next_pre_pos = (pre_pos + 1'b1 == c_pre) ? '0 : pre_pos + 1'b1;
            if (pre_cnt != c_pre) next_pre_cnt = pre_cnt + 1'b1;
          end else begin
            next_pre_pos = '0;
            next_pre_cnt = '0;
          end
        end
      end
      CAP_DLY: begin
        if (rec != REC_RUN) next_cap = CAP_IDLE;
        else if (ms_tick) begin
          next_dly_cnt = dly_cnt + 1'b1;
          if (dly_cnt + 1'b1 >= c_dly) begin
            do_commit = 1'b1;
            com_pre = '0;
            com_post = c_len;
          end
        end
      end
      CAP_POST: begin
        if (sample_tick) begin
          next_cap_we = 1'b1;
          next_cap_addr = tail + wr_off[AW-1:0];
          next_wr_off = wr_off + 1'b1;
          next_post_cnt = post_cnt + 1'b1;
          used_add = 1'b1;
        end
        fin_len = next_wr_off;
        if (rec != REC_RUN) begin
          fin = 1'b1;
          next_cap = CAP_IDLE;
        end else if (trig_in && c_str && str_cnt >= 20'(GAP_CYC)
                     && free >= post_tgt + 1'b1) begin
          next_post_cnt = '0;
          next_str_cnt = '0;
        end else if (next_post_cnt >= post_tgt) begin
          fin = 1'b1;
          next_cap = CAP_PRE;
          next_pre_pos = '0;
          next_pre_cnt = '0;
        end
        if (fin) begin
          next_open = 1'b0;
          next_tail = tail + fin_len[AW-1:0];
        end
      end
    endcase
    if (do_commit) begin
      next_pre_pos = '0;
      next_pre_cnt = '0;
      if (free >= com_pre + com_post &&
          pend != PW'(`DSRC_MAX_PEND)) begin
        push = 1'b1;
        used_pre = com_pre;
        next_gap_cnt = '0;
        next_sweeps = sweeps + 1'b1;
        next_overrun = 1'b0;
        next_cur_ptr = wr_ptr;
        next_wr_ptr = dsrc_inc(wr_ptr);
        next_wr_off = com_pre;
        next_post_cnt = '0;
        next_post_tgt = com_post;
        if (com_post == '0) begin
          next_tail = tail + com_pre[AW-1:0];
          next_cap = CAP_PRE;
        end else begin
          next_open = 1'b1;
          next_cap = CAP_POST;
        end
      end else begin
        mark_set = 1'b1;
        next_overrun = 1'b1;
        next_cap = CAP_PRE;
      end
    end
  end

  // capture flops; descriptor memory is in the next block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= CAP_IDLE;
      pre_pos <= '0;
      pre_cnt <= '0;
      tail <= '0;
      wr_off <= '0;
      post_cnt <= '0;
      post_tgt <= '0;
      dly_cnt <= '0;
      gap_cnt <= '0;
      str_cnt <= '0;
      sweeps <= '0;
      wr_ptr <= '0;
      cur_ptr <= '0;
      open <= 1'b0;
      overrun <= 1'b0;
      cap_we <= 1'b0;
      cap_addr <= '0;
    end else begin
      cap <= next_cap;
      pre_pos <= next_pre_pos;
      pre_cnt <= next_pre_cnt;
      tail <= next_tail;
      wr_off <= next_wr_off;
      post_cnt <= next_post_cnt;
      post_tgt <= next_post_tgt;
      dly_cnt <= next_dly_cnt;
      gap_cnt <= next_gap_cnt;
      str_cnt <= next_str_cnt;
      sweeps <= (arm_p && rec != REC_RUN && rec != REC_SUSP) ?
                '0 : next_sweeps;
      wr_ptr <= next_wr_ptr;
      cur_ptr <= next_cur_ptr;
      open <= next_open;
      overrun <= next_overrun;
      cap_we <= next_cap_we;
      cap_addr <= next_cap_addr;
    end
  end

  // descriptor memory, no reset
  always_ff @(posedge pclk) begin
    if (push) begin
      d_base[wr_ptr] <= tail;
      d_pre[wr_ptr] <= com_pre;
      d_rot[wr_ptr] <= push_rot;
      d_len[wr_ptr] <= com_pre;
    end
    if (fin) d_len[cur_ptr] <= fin_len;
  end

  // storage arbiter: notes, markers, continuous, then sweeps
  always_comb begin
    next_st_valid = st_valid && !st_ready;
    next_st_kind = st_kind;
    next_st_chan = st_chan;
    next_st_data = st_data;
    next_s_idx = s_idx;
    next_s_ch = s_ch;
    next_rd_ptr = rd_ptr;
    next_phase = phase + 1'b1;
    next_thr = thr;
    next_note_p = note_p;
    next_note_v = note_v;
    next_mark_p = mark_p;
    cont_ready = 1'b0;
    rel = 1'b0;
    head_open = open && (rd_ptr == cur_ptr);
    lim = head_open ? wr_off : d_len[rd_ptr];
    nx_ch = dsrc_next_ch(c_chan, s_ch + 1'b1);
    allow = ({1'b0, phase} < (`DSRC_THR_STOP - thr));
    if (ms_tick) begin
      if (rate_over && thr != `DSRC_THR_STOP) next_thr = thr + 1'b1;
      else if (!rate_over && thr != '0) next_thr = thr - 1'b1;
    end
    if (!st_valid || st_ready) begin
      if (note_p) begin
        next_st_valid = 1'b1;
        next_st_kind = KIND_NOTE;
        next_st_data = {31'h0, note_v};
        next_note_p = 1'b0;
      end else if (mark_p) begin
        next_st_valid = 1'b1;
        next_st_kind = KIND_MARK;
        next_st_data = {14'h0, sweeps};
        next_mark_p = 1'b0;
      end else if (cont_valid) begin
        cont_ready = 1'b1;
        next_st_valid = 1'b1;
        next_st_kind = KIND_CONT;
        next_st_data = cont_data;
      end else if (pend != '0 && !head_open && lim == '0) begin
        rel = 1'b1;
      end else if (pend != '0 && allow && s_idx < lim) begin
        next_st_valid = 1'b1;
        next_st_kind = KIND_SWEEP;
        next_st_chan = s_ch[CW-1:0];
        next_st_data = 32'(dsrc_addr(d_base[rd_ptr], d_rot[rd_ptr],
                                     d_pre[rd_ptr], s_idx));
        next_s_ch = nx_ch;
        if (nx_ch == (CW+1)'(NCH)) begin
          next_s_ch = dsrc_next_ch(c_chan, '0);
          next_s_idx = s_idx + 1'b1;
          rel = !head_open && (s_idx + 1'b1 == lim);
        end
      end
    end
    if (rel) begin
      next_rd_ptr = dsrc_inc(rd_ptr);
      next_s_idx = '0;
      next_s_ch = dsrc_next_ch(c_chan, '0);
    end
    // nothing pending: next sweep starts at lowest enabled channel
    if (pend == '0) begin
      next_s_idx = '0;
      next_s_ch = dsrc_next_ch(c_chan, '0);
    end
    next_used = used + (AW+1)'(used_add) + used_pre -
                (rel ? lim : '0);
    next_pend = pend + PW'(push) - PW'(rel);
    if (note_set) begin
      next_note_p = 1'b1;
      next_note_v = note_dir;
    end
    if (mark_set) next_mark_p = 1'b1;
  end

  // storage flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_valid <= 1'b0;
      st_kind <= KIND_CONT;
      st_chan <= '0;
      st_data <= '0;
      s_idx <= '0;
      s_ch <= '0;
      rd_ptr <= '0;
      used <= '0;
      pend <= '0;
      thr <= '0;
      phase <= '0;
      note_p <= 1'b0;
      note_v <= 1'b0;
      mark_p <= 1'b0;
    end else begin
      st_valid <= next_st_valid;
      st_kind <= next_st_kind;
      st_chan <= next_st_chan;
      st_data <= next_st_data;
      s_idx <= next_s_idx;
      s_ch <= next_s_ch;
      rd_ptr <= next_rd_ptr;
      used <= next_used;
      pend <= next_pend;
      thr <= next_thr;
      phase <= next_phase;
      note_p <= next_note_p;
      note_v <= next_note_v;
      mark_p <= next_mark_p;
    end
  end

endmodule

//--- dsrc_defs.svh
`ifndef DSRC_DEFS_SVH
`define DSRC_DEFS_SVH
// clock and timing
`define DSRC_CLK_HZ 50000000
`define DSRC_MS_US 1000
`define DSRC_GAP_US 2500
`define DSRC_CYC(us) ((us) * (`DSRC_CLK_HZ / 1000000))
// limits
`define DSRC_MAX_DELAY_MS 1000000
`define DSRC_MAX_SWEEPS 200000
`define DSRC_MAX_PEND 2000
`define DSRC_THR_STOP 4'h8
// register byte addresses
`define DSRC_A_CTRL 8'h00
`define DSRC_A_LEN 8'h04
`define DSRC_A_PRE 8'h08
`define DSRC_A_DLY 8'h0c
`define DSRC_A_DUR 8'h10
`define DSRC_A_CHAN 8'h14
`define DSRC_A_STAT 8'h18
`define DSRC_A_SWPS 8'h1c
`define DSRC_A_PEND 8'h20
// control bits
`define DSRC_C_ARM 0
`define DSRC_C_STOP 1
`define DSRC_C_STR 2
// reset values
`define DSRC_R_LEN 32'h0000_0400
`define DSRC_R_PRE 32'h0000_0100
`define DSRC_R_CHAN 32'h0000_00ff
`endif

//--- dsrc_pkg.sv
package dsrc_pkg;
  // recording control states
  typedef enum logic [3:0] {
    REC_IDLE = 4'h1, REC_RUN = 4'h2, REC_SUSP = 4'h4, REC_DONE = 4'h8
  } dsrc_rec_t;
  // sweep capture states
  typedef enum logic [3:0] {
    CAP_IDLE = 4'h1, CAP_PRE = 4'h2, CAP_DLY = 4'h4, CAP_POST = 4'h8
  } dsrc_cap_t;
  // kind of storage entry
  typedef enum logic [1:0] {
    KIND_CONT = 2'h0, KIND_SWEEP = 2'h1, KIND_MARK = 2'h2, KIND_NOTE = 2'h3
  } dsrc_kind_t;
endpackage

//--- dsrc_checker.sv
`timescale 1ns/1ps
// watches the recorder ports for storage, capture and suspend timing
module dsrc_checker #(
  parameter int CW = 3
)(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pslverr,
  input wire logic                 sample_tick,
  input wire logic                 cap_we,
  input wire logic                 rec_active,
  input wire logic                 cont_ready,
  input wire logic [31:0]          cont_data,
  input wire logic                 cont_fifo_full,
  input wire logic                 cont_fifo_empty,
  input wire logic                 media_full,
  input wire logic                 st_valid,
  input wire logic                 st_ready,
  input wire dsrc_pkg::dsrc_kind_t st_kind,
  input wire logic [CW-1:0]        st_chan,
  input wire logic [31:0]          st_data
);
  import dsrc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a stalled entry must not move
  AST_HOLD: assert property (st_valid && !st_ready |=>
    st_valid && $stable(st_data) && $stable(st_kind) && $stable(st_chan))
    else $error("store entry changed while stalled");
  // a taken continuous word is offered next cycle
  AST_CONT: assert property (cont_ready |=> st_valid &&
    st_kind == KIND_CONT && st_data == $past(cont_data))
    else $error("continuous word not forwarded");
  // memory writes only follow a sample
  AST_CAPW: assert property (cap_we |-> $past(sample_tick))
    else $error("capture write without sample");
  // error answer only in an access phase
  AST_ERR: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  // full medium ends recording
  AST_MEDIA: assert property (media_full && rec_active |->
    ##[1:3] !rec_active) else $error("recording kept on full medium");
  // full fifo suspends
  AST_SUSP: assert property (cont_fifo_full && rec_active |->
    ##[1:3] !rec_active) else $error("no suspend on full fifo");
  // start or resume only with empty memory
  AST_RES: assert property ($rose(rec_active) |->
    cont_fifo_empty && !cont_fifo_full) else $error("resume too early");
  // entering suspend leaves a notice in the stream
  AST_NOTE: assert property ($fell(rec_active) && $past(cont_fifo_full) |->
    ##[0:20] st_valid && st_kind == KIND_NOTE && st_data == 32'h0)
    else $error("no suspend notice");
  COV_SWEEP: cover property (st_valid && st_kind == KIND_SWEEP);
  COV_NOTE: cover property (st_valid && st_kind == KIND_NOTE);
  COV_CAP: cover property (cap_we);
endmodule
bind dsrc_top dsrc_checker #(.CW(CW)) u_chk (.*);

//--- dsrc_host.sv
`timescale 1ns/1ps
// host storage path: takes entries, counts them by kind
module dsrc_host (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 st_valid,
  input wire dsrc_pkg::dsrc_kind_t st_kind,
  input wire logic                 stall,
  output logic                     st_ready,
  output logic [3:0][15:0]         cnt
);
  import dsrc_pkg::*;
  logic ph; // pacing phase for a slow host
  // ready every cycle, or every other cycle while stalling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ready <= 1'b0;
      cnt      <= '0;
      ph       <= 1'b0;
    end else begin
      ph       <= ~ph;
      st_ready <= !stall || ph;
      if (st_valid && st_ready) begin
        cnt[st_kind] <= cnt[st_kind] + 16'h1;
      end
    end
  end
endmodule

//--- dsrc_top_tb.sv
`timescale 1ns/1ps
`include "dsrc_defs.svh"
module dsrc_top_tb;
  import dsrc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cont_data, st_data, rdat;
  logic sample_tick, trig_in, cap_we, rec_active, cont_valid, cont_ready;
  logic cont_fifo_full, cont_fifo_empty, media_full, st_valid, st_ready;
  logic rerr, rate_over;
  logic [19:0] cap_addr;
  logic [2:0] st_chan;
  logic [3:0][15:0] cnt;
  dsrc_kind_t st_kind;
  int error_cnt, total_checks;
  dsrc_top #(.MS_CYC(10), .GAP_CYC(20)) u_dut (.*);
  dsrc_host u_host (.*);
  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // one apb transfer, answer taken at the pready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  // n sample pulses two cycles apart
  task tk(input int n);
    repeat (n) begin
      @(posedge pclk) sample_tick <= 1'b1;
      @(posedge pclk) sample_tick <= 1'b0;
    end
  endtask
  task tg;
    @(posedge pclk) trig_in <= 1'b1;
    @(posedge pclk) trig_in <= 1'b0;
  endtask
  task close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #400us;
    error_cnt++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sample_tick, trig_in} = '0;
    {cont_valid, cont_data, cont_fifo_full, media_full, stall} = '0;
    rate_over = 1'b0;
    cont_fifo_empty = 1'b1;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `DSRC_A_LEN, 0); chk("len", `DSRC_R_LEN, rdat);
    apb(0, `DSRC_A_PRE, 0); chk("pre", `DSRC_R_PRE, rdat);
    apb(0, `DSRC_A_CHAN, 0); chk("chan", `DSRC_R_CHAN, rdat);
    apb(1, 8'h40, 1); chk("slverr", 1, rerr);
    apb(1, `DSRC_A_LEN, 8);
    apb(1, `DSRC_A_PRE, 4);
    apb(1, `DSRC_A_CHAN, 3);
    apb(1, `DSRC_A_CTRL, 1);
    // early trigger: 2 pre + 4 post samples on 2 channels
    tk(2); tg(); tk(4);
    tg(); // inside the gap, ignored
    repeat (20) @(posedge pclk);
    cont_data  <= 32'h5a;
    cont_valid <= 1'b1;
    repeat (3) @(posedge pclk);
    cont_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("cont words", 3, {16'h0, cnt[0]});
    // full sweep of 8 samples with a slow host
    tk(4); tg(); stall <= 1'b1; tk(4);
    repeat (150) @(posedge pclk);
    stall <= 1'b0;
    repeat (150) @(posedge pclk);
    chk("sweep words", 28, {16'h0, cnt[1]});
    apb(0, `DSRC_A_SWPS, 0); chk("sweeps", 2, rdat);
    apb(0, `DSRC_A_PEND, 0); chk("pending", 0, rdat);
    {cont_fifo_full, cont_fifo_empty} <= 2'b10;
    repeat (5) @(posedge pclk);
    apb(0, `DSRC_A_STAT, 0); chk("suspend", 2, {30'h0, rdat[1:0]});
    {cont_fifo_full, cont_fifo_empty} <= 2'b01;
    repeat (20) @(posedge pclk);
    chk("resume", 1, {31'h0, rec_active});
    chk("notices", 2, {16'h0, cnt[3]});
    media_full <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(0, `DSRC_A_STAT, 0); chk("done", 8, {28'h0, rdat[3:0]});
    media_full <= 1'b0;
    apb(1, `DSRC_A_DLY, 2);
    apb(1, `DSRC_A_CTRL, 5);
    // delayed sweep, stretched once: 4 + 8 post samples on 2 channels
    tk(2); tg(); repeat (30) @(posedge pclk); tk(4);
    tg(); tk(8); repeat (60) @(posedge pclk);
    chk("stretched words", 52, {16'h0, cnt[1]});
    rate_over <= 1'b1;
    repeat (100) @(posedge pclk);
    apb(0, `DSRC_A_STAT, 0); chk("throttle", 8, {28'h0, rdat[11:8]});
    close_out();
  end
endmodule
